// file: rtl/bcacc_pkg.sv
// constants, register map and types of the battery capacity accounting core
package bcacc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned SD_DAY_S          = 86_400;
    localparam int unsigned SD_SUBTICKS       = 2048;
    localparam int unsigned SD_SUB_SHIFT      = 11;
    localparam int unsigned SD_TICK_CYCLES_DEF =
        int'((64'(SD_DAY_S) * 64'(CLK_HZ)) / 64'(SD_SUBTICKS));
    localparam int unsigned SD_CNT_W          = 30;
    localparam int unsigned SD_ACC_W          = 24;
    localparam int unsigned MEAS_PER_HOUR     = 3600;
    localparam int unsigned HI_RATE_DIV       = 2;

    ////////////////////////////////////////////////////////////////////////////
    // measurement
    localparam int unsigned             SV_W          = 16;
    localparam logic signed [SV_W-1:0]  CHG_THRESH_UV = 16'sh00fa;
    localparam logic signed [SV_W-1:0]  DIS_THRESH_UV = 16'shff06;
    localparam int unsigned             SCALE_SHIFT   = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [6:0] ADDR_FLAGS = 7'h01;
    localparam logic [6:0] ADDR_NACH  = 7'h03;
    localparam logic [6:0] ADDR_LMD   = 7'h05;
    localparam logic [6:0] ADDR_CPI   = 7'h09;
    localparam logic [6:0] ADDR_VSB   = 7'h0b;
    localparam logic [6:0] ADDR_TEMP_RATE_COMP_CAPACITY  = 7'h0d;
    localparam logic [6:0] ADDR_RATE_COMP_CAPACITY  = 7'h0e;
    localparam logic [6:0] ADDR_MAX_CELL_VOLTAGE_LIMIT  = 7'h15;
    localparam logic [6:0] ADDR_NACL  = 7'h17;
    localparam logic [6:0] ADDR_DCR   = 7'h18;

    localparam int unsigned FLG_CHGS = 7;
    localparam int unsigned FLG_BRP  = 6;
    localparam int unsigned FLG_PROT = 5;
    localparam int unsigned FLG_CI   = 4;
    localparam int unsigned FLG_VDQ  = 3;
    localparam int unsigned FLG_ONE  = 2;

    localparam logic [7:0] LMD_RESET = 8'h78;
    localparam logic [7:0] MAX_CELL_VOLTAGE_LIMIT_RESET = 8'hff;
    localparam logic [7:0] CNT8_MAX  = 8'hff;
    localparam logic [7:0] CI_LIMIT  = 8'h40;

    ////////////////////////////////////////////////////////////////////////////
    // temperature band index, 10 degree steps
    localparam logic [3:0] TB_LE_M20  = 4'h1;
    localparam logic [3:0] TB_ZERO    = 4'h4;
    localparam logic [3:0] TB_TEN     = 4'h5;
    localparam logic [3:0] TB_SIXTY   = 4'ha;
    localparam logic [3:0] TB_SEVENTY = 4'hb;
    localparam int unsigned SD_SHIFT_COLD = 11;
    localparam int unsigned SD_SHIFT_HOT  = 4;
    localparam int unsigned SD_SHIFT_BASE = 15;

    ////////////////////////////////////////////////////////////////////////////
    // compensation factors in percent of learned capacity
    localparam int unsigned PCT_DEN    = 100;
    localparam int unsigned G_RATE_PCT = 5;
    localparam int unsigned G_T1_PCT   = 5;
    localparam int unsigned G_T2_PCT   = 15;
    localparam int unsigned G_T3_PCT   = 37;
    localparam int unsigned C_RATE_PCT = 10;
    localparam int unsigned C_T1_PCT   = 10;
    localparam int unsigned C_T2_PCT   = 30;
    localparam int unsigned C_T3_PCT   = 60;
    localparam int unsigned VDQ_SD_PCT = 6;
    localparam int unsigned CAP94_NUM  = 15401;
    localparam int unsigned CAP94_SHIFT = 14;

    typedef enum logic [1:0] {CS_IDLE, CS_ONE, CS_VALID} bcacc_chg_t;

endpackage

// file: rtl/bcacc_pin_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module bcacc_pin_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // only stages two and three are compared; stage one may be metastable
    always_ff @(posedge clk)
    begin
        if (rst)
            level_out <= 1'b0;
        else if (s2_q == s3_q)
            level_out <= s3_q;
    end
endmodule
`default_nettype wire

// file: rtl/bcacc_core.sv
// battery capacity accounting core: counters, compensation and charge fet control
`timescale 1ns/1ps
`default_nettype none
module bcacc_core
    import bcacc_pkg::*;
#(
    parameter int unsigned SD_TICK_CYCLES = SD_TICK_CYCLES_DEF
)
(
    input  wire logic            REF_CLK,
    input  wire logic            SYS_RST,
    input  wire logic            MEAS_VALID,
    input  wire logic [SV_W-1:0] SENSE_VOLTAGE_WITH_OFFSET,
    input  wire logic [3:0]      TEMP_BAND,
    input  wire logic [7:0]      BATTERY_SENSE_VOLTAGE,
    input  wire logic            ANODE_COKE,
    input  wire logic            SELF_DISCHARGE_SELECT_PIN,
    input  wire logic            PROTECTOR_STATE_INPUT,
    input  wire logic            LEARN_STROBE,
    input  wire logic [6:0]      REG_ADDR,
    input  wire logic [7:0]      REG_WDATA,
    input  wire logic            REG_WR,
    output logic      [7:0]      REG_RDATA,
    output logic      [7:0]      DISPLAY_CAPACITY,
    output logic                 CHARGE_FET_CONTROL
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sd_off;
    logic prot_state;

    bcacc_pin_sync u_sd_sync
    (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .pin_in    (SELF_DISCHARGE_SELECT_PIN),
        .level_out (sd_off)
    );

    bcacc_pin_sync u_prot_sync
    (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .pin_in    (PROTECTOR_STATE_INPUT),
        .level_out (prot_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state
    bcacc_chg_t             chg_state_q;
    logic [15:0]            nac_q;
    logic [7:0]             lmd_q;
    logic [7:0]             dcr_q;
    logic [7:0]             dcr_frac_q;
    logic [7:0]             cpi_q;
    logic [7:0]             max_cell_voltage_limit_q;
    logic                   ci_q;
    logic                   vdq_q;
    logic                   brp_q;
    logic                   rate_hold_q;
    logic [15:0]            vdq_base_q;
    logic [15:0]            sd_since_q;
    logic [SD_CNT_W-1:0]    sd_cnt_q;
    logic [SD_ACC_W-1:0]    sd_acc_q;
    logic [15:0]            rate_comp_capacity_q;
    logic [15:0]            temp_rate_comp_capacity_q;

    ////////////////////////////////////////////////////////////////////////////
    // measurement classification
    logic signed [SV_W-1:0] sv;
    logic [SV_W:0]          mag;
    logic [15:0]            step;
    logic                   is_chg;
    logic                   is_dis;
    logic                   chg_upd;
    logic                   dis_upd;
    logic                   valid_chg;
    logic                   hi_rate;
    logic                   cold;
    logic [15:0]            full_cap;
    logic [15:0]            cap94;
    logic [15:0]            chg_cap;
    logic                   at_full;
    logic                   learn_evt;

    assign sv      = signed'(SENSE_VOLTAGE_WITH_OFFSET);
    assign mag     = sv[SV_W-1] ? (SV_W+1)'(-$signed({sv[SV_W-1], sv})) : {1'b0, sv};
    assign step    = 16'(mag >> SCALE_SHIFT);
    assign is_chg  = sv > CHG_THRESH_UV;
    assign is_dis  = sv < DIS_THRESH_UV;
    assign chg_upd = MEAS_VALID && is_chg;
    assign dis_upd = MEAS_VALID && is_dis;
    assign valid_chg = chg_upd && (chg_state_q == CS_ONE);
    assign cold    = TEMP_BAND < TB_ZERO;
    assign full_cap = {lmd_q, 8'h00};
    assign cap94   = 16'((32'(full_cap) * 32'(CAP94_NUM)) >> CAP94_SHIFT);
    assign chg_cap = cold ? cap94 : full_cap;
    assign at_full = nac_q == full_cap;
    assign learn_evt = LEARN_STROBE && vdq_q;
    // rate in counts per hour against half of learned capacity, i.e. 0.5C
    assign hi_rate = is_dis &&
                     (32'(step) * 32'(MEAS_PER_HOUR) >= 32'(full_cap) / 32'(HI_RATE_DIV));

    ////////////////////////////////////////////////////////////////////////////
    // valid charge qualification; a dead-band sample is the filter time-out
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            chg_state_q <= CS_IDLE;
        else if (MEAS_VALID)
        begin
            case (chg_state_q)
                CS_IDLE:  chg_state_q <= is_chg ? CS_ONE : CS_IDLE;
                CS_ONE:   chg_state_q <= is_chg ? CS_VALID : CS_IDLE;
                CS_VALID: chg_state_q <= is_chg ? CS_VALID : CS_IDLE;
                default:  chg_state_q <= CS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-discharge timebase: day split into sub-ticks, fraction accumulated
    logic                sd_tick;
    logic [4:0]          sd_shift;
    logic [SD_ACC_W-1:0] sd_thr;
    logic [SD_ACC_W-1:0] sd_sum;
    logic                sd_hit;

    assign sd_tick = sd_cnt_q == SD_CNT_W'(SD_TICK_CYCLES - 1);

    always_comb
    begin
        if (TEMP_BAND <= TB_ZERO)
            sd_shift = 5'(SD_SHIFT_COLD);
        else if (TEMP_BAND >= TB_SEVENTY)
            sd_shift = 5'(SD_SHIFT_HOT);
        else
            sd_shift = 5'(SD_SHIFT_BASE) - {1'b0, TEMP_BAND};
    end

    assign sd_thr = SD_ACC_W'(1) << (sd_shift + 5'(SD_SUB_SHIFT));
    assign sd_sum = sd_acc_q + SD_ACC_W'(nac_q);
    assign sd_hit = sd_tick && !sd_off && (sd_sum >= sd_thr) && (nac_q != 16'h0000);

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || sd_tick)
            sd_cnt_q <= '0;
        else
            sd_cnt_q <= sd_cnt_q + SD_CNT_W'(1);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || sd_off)
            sd_acc_q <= '0;
        else if (sd_tick)
            sd_acc_q <= (sd_sum >= sd_thr) ? sd_sum - sd_thr : sd_sum;
    end

    ////////////////////////////////////////////////////////////////////////////
    // nominal capacity counter
    logic [16:0] nac_sum;
    logic [15:0] nac_after_io;
    logic [15:0] nac_d;

    assign nac_sum = {1'b0, nac_q} + {1'b0, step};

    always_comb
    begin
        nac_after_io = nac_q;
        if (chg_upd)
        begin
            // a cold cap below the present count must not pull the count down
            if (nac_q >= chg_cap)
                nac_after_io = nac_q;
            else if (nac_sum > {1'b0, chg_cap})
                nac_after_io = chg_cap;
            else
                nac_after_io = nac_sum[15:0];
        end
        else if (dis_upd)
            nac_after_io = (nac_q > step) ? nac_q - step : 16'h0000;
        nac_d = nac_after_io;
        if (sd_hit && (nac_after_io != 16'h0000))
            nac_d = nac_after_io - 16'h0001;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            nac_q <= 16'h0000;
        else if (REG_WR && REG_ADDR == ADDR_NACH)
            nac_q <= {REG_WDATA, nac_q[7:0]};
        else if (REG_WR && REG_ADDR == ADDR_NACL)
            nac_q <= {nac_q[15:8], REG_WDATA};
        else
            nac_q <= nac_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // discharge counter: fraction in low byte, saturating whole counts
    logic [16:0] frac_add;
    logic [17:0] frac_sum;
    logic [9:0]  dcr_sum;

    assign frac_add = (dis_upd ? {1'b0, step} : 17'h00000) + (sd_hit ? 17'h00001 : 17'h00000);
    assign frac_sum = {10'h000, dcr_frac_q} + {1'b0, frac_add};
    assign dcr_sum  = {2'b00, dcr_q} + frac_sum[17:8];

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || at_full)
        begin
            dcr_q      <= 8'h00;
            dcr_frac_q <= 8'h00;
        end
        else if (REG_WR && REG_ADDR == ADDR_DCR)
            dcr_q <= REG_WDATA;
        else
        begin
            dcr_frac_q <= frac_sum[7:0];
            dcr_q      <= (dcr_sum > {2'b00, CNT8_MAX}) ? CNT8_MAX : dcr_sum[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // learned capacity; a short discharge count is floored at 60/64 of old value
    logic [7:0] lmd94;

    assign lmd94 = 8'((16'(lmd_q) * 16'(CAP94_NUM >> 8)) >> (CAP94_SHIFT - 8));

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            lmd_q <= LMD_RESET;
        else if (REG_WR && REG_ADDR == ADDR_LMD)
            lmd_q <= REG_WDATA;
        else if (learn_evt)
            lmd_q <= (dcr_q < lmd94) ? lmd94 : dcr_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // inaccuracy counter and flag
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            cpi_q <= 8'h00;
        else if (valid_chg && cpi_q != CNT8_MAX)
            cpi_q <= cpi_q + 8'h01;
        else if (learn_evt)
            cpi_q <= 8'h00;
        else if (REG_WR && REG_ADDR == ADDR_CPI)
            cpi_q <= REG_WDATA;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            ci_q <= 1'b1;
        else if (valid_chg && cpi_q >= CI_LIMIT - 8'h01)
            ci_q <= 1'b1;
        else if (learn_evt)
            ci_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // valid discharge flag with self-discharge watch since it was set
    logic vdq_set;
    logic vdq_sd_over;

    assign vdq_set     = dis_upd && at_full;
    assign vdq_sd_over = 32'(sd_since_q) * 32'(PCT_DEN) > 32'(vdq_base_q) * 32'(VDQ_SD_PCT);

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            vdq_q      <= 1'b0;
            vdq_base_q <= 16'h0000;
            sd_since_q <= 16'h0000;
        end
        else if (vdq_set)
        begin
            vdq_q      <= 1'b1;
            vdq_base_q <= nac_q;
            sd_since_q <= 16'h0000;
        end
        else
        begin
            if (valid_chg || learn_evt || vdq_sd_over)
                vdq_q <= 1'b0;
            if (sd_hit && sd_since_q != 16'hffff)
                sd_since_q <= sd_since_q + 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            brp_q <= 1'b1;
        else if (chg_state_q == CS_VALID && at_full)
            brp_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate and temperature compensation
    int unsigned rate_pct;
    int unsigned temp_pct;
    logic [15:0] rate_red;
    logic [15:0] temp_red;
    logic [15:0] rate_comp_capacity_d;
    logic [15:0] temp_rate_comp_capacity_d;

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            rate_hold_q <= 1'b0;
        else if (MEAS_VALID && hi_rate)
            rate_hold_q <= 1'b1;
        else if (valid_chg)
            rate_hold_q <= 1'b0;
    end

    always_comb
    begin
        rate_pct = ANODE_COKE ? C_RATE_PCT : G_RATE_PCT;
        if (TEMP_BAND >= TB_TEN)
            temp_pct = 0;
        else if (TEMP_BAND == TB_ZERO)
            temp_pct = ANODE_COKE ? C_T1_PCT : G_T1_PCT;
        else if (TEMP_BAND > TB_LE_M20)
            temp_pct = ANODE_COKE ? C_T2_PCT : G_T2_PCT;
        else
            temp_pct = ANODE_COKE ? C_T3_PCT : G_T3_PCT;
        rate_red = rate_hold_q ? 16'((32'(full_cap) * rate_pct) / PCT_DEN) : 16'h0000;
        temp_red = 16'((32'(full_cap) * temp_pct) / PCT_DEN);
        rate_comp_capacity_d   = (nac_q > rate_red) ? nac_q - rate_red : 16'h0000;
        temp_rate_comp_capacity_d   = (rate_comp_capacity_d > temp_red) ? rate_comp_capacity_d - temp_red : 16'h0000;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            rate_comp_capacity_q <= 16'h0000;
            temp_rate_comp_capacity_q <= 16'h0000;
        end
        else
        begin
            rate_comp_capacity_q <= rate_comp_capacity_d;
            temp_rate_comp_capacity_q <= temp_rate_comp_capacity_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pack protection and outputs
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            max_cell_voltage_limit_q <= MAX_CELL_VOLTAGE_LIMIT_RESET;
        else if (REG_WR && REG_ADDR == ADDR_MAX_CELL_VOLTAGE_LIMIT)
            max_cell_voltage_limit_q <= REG_WDATA;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            CHARGE_FET_CONTROL <= 1'b0;
        else
            CHARGE_FET_CONTROL <= !(BATTERY_SENSE_VOLTAGE > max_cell_voltage_limit_q || cold || TEMP_BAND >= TB_SIXTY);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            DISPLAY_CAPACITY <= 8'h00;
        else
            DISPLAY_CAPACITY <= temp_rate_comp_capacity_q[15:8];
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, one cycle latency
    logic [7:0] flags;

    always_comb
    begin
        flags           = 8'h00;
        flags[FLG_CHGS] = chg_state_q != CS_IDLE;
        flags[FLG_BRP]  = brp_q;
        flags[FLG_PROT] = prot_state;
        flags[FLG_CI]   = ci_q;
        flags[FLG_VDQ]  = vdq_q;
        flags[FLG_ONE]  = 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            REG_RDATA <= 8'h00;
        else
        begin
            case (REG_ADDR)
                ADDR_FLAGS: REG_RDATA <= flags;
                ADDR_NACH:  REG_RDATA <= nac_q[15:8];
                ADDR_NACL:  REG_RDATA <= nac_q[7:0];
                ADDR_LMD:   REG_RDATA <= lmd_q;
                ADDR_CPI:   REG_RDATA <= cpi_q;
                ADDR_VSB:   REG_RDATA <= BATTERY_SENSE_VOLTAGE;
                ADDR_TEMP_RATE_COMP_CAPACITY:  REG_RDATA <= temp_rate_comp_capacity_q[15:8];
                ADDR_RATE_COMP_CAPACITY:  REG_RDATA <= rate_comp_capacity_q[15:8];
                ADDR_MAX_CELL_VOLTAGE_LIMIT:  REG_RDATA <= max_cell_voltage_limit_q;
                ADDR_DCR:   REG_RDATA <= dcr_q;
                default:    REG_RDATA <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: verif/bcacc_core_chk.sv
// port checker for the capacity accounting core
`timescale 1ns/1ps
`default_nettype none
module bcacc_core_chk
    import bcacc_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       SYS_RST,
    input wire logic       PROTECTOR_STATE_INPUT,
    input wire logic [3:0] TEMP_BAND,
    input wire logic [7:0] BATTERY_SENSE_VOLTAGE,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_RDATA,
    input wire logic [7:0] DISPLAY_CAPACITY,
    input wire logic       CHARGE_FET_CONTROL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // shadow of the voltage limit, so the fet decision can be judged from the ports alone
    logic [7:0] lim_q;
    always_ff @(posedge REF_CLK)
        if (SYS_RST)
            lim_q <= MAX_CELL_VOLTAGE_LIMIT_RESET;
        else if (REG_WR && REG_ADDR == ADDR_MAX_CELL_VOLTAGE_LIMIT)
            lim_q <= REG_WDATA;
    ////////////////////////////////////////
    sequence prot_held(logic b);
        (PROTECTOR_STATE_INPUT == b)[*8] ##0 REG_ADDR == ADDR_FLAGS;
    endsequence
    sequence lim_wr;
        REG_WR && REG_ADDR == ADDR_MAX_CELL_VOLTAGE_LIMIT ##1 REG_ADDR == ADDR_MAX_CELL_VOLTAGE_LIMIT && !REG_WR;
    endsequence
    a_fet_cold: assert property (TEMP_BAND < TB_ZERO |=> !CHARGE_FET_CONTROL)
        else $error("fet on while cold");
    a_fet_hot: assert property (TEMP_BAND >= TB_SIXTY |=> !CHARGE_FET_CONTROL)
        else $error("fet on while hot");
    a_fet_volt: assert property (BATTERY_SENSE_VOLTAGE > lim_q |=> !CHARGE_FET_CONTROL)
        else $error("fet on over limit");
    a_fet_allow: assert property (TEMP_BAND >= TB_ZERO && TEMP_BAND < TB_SIXTY
        && BATTERY_SENSE_VOLTAGE <= lim_q |=> CHARGE_FET_CONTROL) else $error("fet off in range");
    a_limit_read: assert property (lim_wr |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("limit readback wrong");
    a_prot_set: assert property (prot_held(1'b1) |=> REG_RDATA[FLG_PROT])
        else $error("protector flag not set");
    a_prot_clear: assert property (prot_held(1'b0) |=> !REG_RDATA[FLG_PROT])
        else $error("protector flag not clear");
    a_disp_temp_rate_comp_capacity: assert property ((REG_ADDR == ADDR_TEMP_RATE_COMP_CAPACITY)[*2] |-> DISPLAY_CAPACITY == REG_RDATA)
        else $error("display differs from compensated capacity");
endmodule
`default_nettype wire

// file: verif/bcacc_pack_model.sv
// sense resistor model: one measurement per call
`timescale 1ns/1ps
`default_nettype none
module bcacc_pack_model
    import bcacc_pkg::*;
(
    input  wire logic            clk,
    output logic                 meas_valid,
    output logic      [SV_W-1:0] sense_v
);
    initial
    begin
        meas_valid = 1'b0;
        sense_v    = 16'h0000;
    end
    // the inverse between samples keeps a stale value from passing as fresh
    task automatic samp(input logic [SV_W-1:0] x);
        meas_valid = 1'b1;
        sense_v    = x;
        @(posedge clk);
        #2 meas_valid = 1'b0;
        sense_v    = ~x;
        repeat (4) @(posedge clk);
        #2;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the capacity accounting core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bcacc_pkg::*;
    logic        clk, rst, coke, sdp, lrn, wr, prot, mv, cfc;
    logic [3:0]  band;
    logic [6:0]  addr;
    logic [7:0]  wd, battery_sense_voltage, rdata, disp;
    logic [15:0] sv;
    int          num_errors = 0, n_compared = 0, cyc = 0;
    localparam logic [3:0] CB [7] = '{4'h4, 4'h3, 4'h1, 4'h4, 4'h3, 4'h1, 4'h6};
    localparam logic [7:0] CP [7] = '{8'h05, 8'h0f, 8'h25, 8'h0a, 8'h1e, 8'h3c, 8'h00};
    always #25 clk = ~clk;
    bcacc_pack_model pack_i (.clk(clk), .meas_valid(mv), .sense_v(sv));
    // short self-discharge tick keeps the run small
    bcacc_core #(.SD_TICK_CYCLES(16)) bcacc_core_i (.REF_CLK(clk), .SYS_RST(rst), .MEAS_VALID(mv),
        .SENSE_VOLTAGE_WITH_OFFSET(sv), .TEMP_BAND(band), .BATTERY_SENSE_VOLTAGE(battery_sense_voltage), .ANODE_COKE(coke),
        .SELF_DISCHARGE_SELECT_PIN(sdp), .PROTECTOR_STATE_INPUT(prot), .LEARN_STROBE(lrn), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RDATA(rdata), .DISPLAY_CAPACITY(disp), .CHARGE_FET_CONTROL(cfc));
    ////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        tk(1);
        wr = 1'b0;
        tk(1);
    endtask
    task automatic rreg(input logic [6:0] a, input logic [7:0] e);
        addr = a;
        tk(2);
        cmp(rdata, e);
    endtask
    task automatic fet(input logic [3:0] b, input logic [7:0] s, input logic e);
        band = b;
        battery_sense_voltage = s;
        tk(3);
        cmp({7'h00, cfc}, {7'h00, e});
    endtask
    task automatic pair;
        pack_i.samp(16'h0000);
        pack_i.samp(16'h03e8);
        pack_i.samp(16'h03e8);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        coke = 1'b0;
        sdp = 1'b1;
        lrn = 1'b0;
        wr = 1'b0;
        prot = 1'b0;
        band = 4'h6;
        addr = 7'h00;
        wd = 8'h00;
        battery_sense_voltage = 8'h00;
        tk(6);
        rst = 1'b0;
        tk(5);
        rreg(ADDR_MAX_CELL_VOLTAGE_LIMIT, MAX_CELL_VOLTAGE_LIMIT_RESET);
        rreg(ADDR_FLAGS, 8'h54);
        wreg(ADDR_MAX_CELL_VOLTAGE_LIMIT, 8'h80);
        rreg(ADDR_MAX_CELL_VOLTAGE_LIMIT, 8'h80);
        for (int b = 0; b < 13; b++)
            fet(4'(b), 8'h00, b >= 4 && b < 10);
        fet(4'h6, 8'h81, 1'b0);
        fet(4'h6, 8'h80, 1'b1);
        $display("fet test done");
        pack_i.samp(16'h03e8);
        rreg(ADDR_NACL, 8'h3e);
        pack_i.samp(16'h03e8);
        rreg(ADDR_CPI, 8'h01);
        pack_i.samp(16'h03e8);
        pack_i.samp(16'h00fa);
        pack_i.samp(16'hff06);
        rreg(ADDR_NACL, 8'hba);
        pack_i.samp(16'h00fb);
        rreg(ADDR_NACL, 8'hc9);
        pack_i.samp(16'hff05);
        rreg(ADDR_NACL, 8'hba);
        wreg(ADDR_NACL, 8'h10);
        pack_i.samp(16'hfc18);
        rreg(ADDR_NACL, 8'h00);
        wreg(ADDR_DCR, 8'h33);
        wreg(ADDR_NACH, 8'h78);
        pack_i.samp(16'h03e8);
        rreg(ADDR_NACL, 8'h00);
        rreg(ADDR_DCR, 8'h00);
        $display("counting test done");
        pack_i.samp(16'hfc18);
        rreg(ADDR_FLAGS, 8'h5c);
        lrn = 1'b1;
        tk(1);
        lrn = 1'b0;
        rreg(ADDR_CPI, 8'h00);
        rreg(ADDR_FLAGS, 8'h44);
        wreg(ADDR_NACH, 8'h10);
        wreg(ADDR_CPI, 8'h3f);
        pair;
        rreg(ADDR_FLAGS, 8'hd4);
        wreg(ADDR_CPI, 8'hff);
        pair;
        rreg(ADDR_CPI, 8'hff);
        $display("learn test done");
        wreg(ADDR_LMD, 8'h64);
        wreg(ADDR_NACH, 8'h60);
        wreg(ADDR_NACL, 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            coke = i >= 3;
            band = CB[i];
            tk(2);
            rreg(ADDR_TEMP_RATE_COMP_CAPACITY, 8'h60 - CP[i]);
            cmp(disp, 8'h60 - CP[i]);
            rreg(ADDR_RATE_COMP_CAPACITY, 8'h60);
        end
        coke = 1'b0;
        pack_i.samp(16'hfc18);
        rreg(ADDR_RATE_COMP_CAPACITY, 8'h5a);
        pack_i.samp(16'h0000);
        coke = 1'b1;
        rreg(ADDR_RATE_COMP_CAPACITY, 8'h55);
        pair;
        rreg(ADDR_RATE_COMP_CAPACITY, 8'h60);
        prot = 1'b1;
        tk(10);
        rreg(ADDR_FLAGS, 8'hf4);
        prot = 1'b0;
        tk(10);
        rreg(ADDR_FLAGS, 8'hd4);
        $display("compensation test done");
        band = 4'hc;
        tk(1500);
        rreg(ADDR_NACH, 8'h60);
        sdp = 1'b0;
        tk(1500);
        cmp({7'h00, rdata < 8'h60}, 8'h01);
        $display("self-discharge test done");
        // cold charge must stop at 0.94 of learned capacity 64h, i.e. 5e00h
        sdp = 1'b1;
        band = 4'h3;
        wreg(ADDR_NACH, 8'h5d);
        wreg(ADDR_NACL, 8'hf0);
        pack_i.samp(16'h03e8);
        rreg(ADDR_NACH, 8'h5e);
        rreg(ADDR_NACL, 8'h00);
        $display("cold charge test done");
        end_of_test();
    end
endmodule
bind bcacc_core bcacc_core_chk bcacc_core_chk_i (.REF_CLK, .SYS_RST, .PROTECTOR_STATE_INPUT, .TEMP_BAND,
    .BATTERY_SENSE_VOLTAGE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA, .DISPLAY_CAPACITY, .CHARGE_FET_CONTROL);
`default_nettype wire
